// File: i2cs_map.svh
`ifndef I2CS_MAP_SVH
`define I2CS_MAP_SVH

// ****************************************
// Addressing
// ****************************************
`define I2CS_SLAVE_ADDR  7'h18
`define I2CS_GCALL_ADDR  7'h00

// ****************************************
// Register space
// ****************************************
`define I2CS_REG_DEPTH   256
`define I2CS_REG_RST     8'h00
`define I2CS_GCE_REG     8'h22
`define I2CS_GCE_BIT     5

// ****************************************
// Bit slots within one byte frame
// ****************************************
`define I2CS_LAST_BIT    4'h7
`define I2CS_ACK_SLOT    4'h8

`endif

// File: i2cs_pkg.sv
`default_nettype none

package i2cs_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_REGADDR,
        ST_WDATA,
        ST_RDATA,
        ST_IGNORE
    } i2cs_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } i2cs_wr_t;

    typedef struct packed {
        logic strap;
        logic scl;
        logic sda;
    } i2cs_pins_t;

endpackage

`default_nettype wire

// File: i2cs_sync.sv
`timescale 1ns/100ps
`default_nettype none

module i2cs_sync #(
    parameter int W = 1
) (
    // Clock
    input  wire logic         clk,
    // Asynchronous levels
    input  wire logic [W-1:0] d,
    // Synchronised levels
    output logic      [W-1:0] q
);

    logic [W-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        meta <= d;
        q    <= meta;
    end

endmodule

`default_nettype wire

// File: i2cs_regfile.sv
`timescale 1ns/100ps
`default_nettype none
`include "i2cs_map.svh"

module i2cs_regfile (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Write port
    input  wire logic             wr_en,
    input  wire i2cs_pkg::i2cs_wr_t wr,
    // Read port
    input  wire logic [7:0]       rd_addr,
    output logic      [7:0]       rd_data,
    // Control bits
    output logic                  gcall_en
);

    logic [7:0] mem [`I2CS_REG_DEPTH];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < `I2CS_REG_DEPTH; i++) begin
                mem[i] <= `I2CS_REG_RST;
            end
        end else if (wr_en) begin
            mem[wr.addr] <= wr.data;
        end
    end

    assign rd_data  = mem[rd_addr];
    assign gcall_en = mem[`I2CS_GCE_REG][`I2CS_GCE_BIT];

endmodule

`default_nettype wire

// File: i2cs_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "i2cs_map.svh"

module i2cs_top (
    // Core clock and reset
    input  wire logic     clk,
    input  wire logic     rst_n,
    // Two-wire link
    input  wire logic     scl,
    input  wire logic     sda_i,
    output logic          sda_o,
    output logic          sda_oe,
    // Protocol strap
    input  wire logic     strap_four_wire,
    output logic          two_wire_en,
    output logic          four_wire_sel,
    // Register write notification
    output logic          reg_wr_stb,
    output i2cs_pkg::i2cs_wr_t reg_wr
);

    // ****************************************
    // Declarations
    // ****************************************
    i2cs_pkg::i2cs_pins_t  pins;
    i2cs_pkg::i2cs_state_t state;
    i2cs_pkg::i2cs_state_t next_state;

    logic       scl_d;
    logic       sda_d;
    logic       strap_done;
    logic [3:0] bit_cnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic       drive_req;
    logic       link_en;
    logic       link_bit;
    logic       link_pull;
    logic       gcall_en;

    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic       bit_ev;
    logic       byte_end;
    logic       ack_ev;
    logic       receiving;
    logic       addr_hit;
    logic [7:0] next_rx;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    i2cs_sync #(
        .W (3)
    ) u_sync (
        .clk (clk),
        .d   ({strap_four_wire, scl, sda_i}),
        .q   (pins)
    );

    // ****************************************
    // Link clock domain
    // ****************************************
    // Bit held a full SCL period; core reads it only after the synced rise
    always_ff @(posedge scl) begin
        link_bit <= sda_i;
    end

    // Drive changes only while SCL is low
    always_ff @(negedge scl) begin
        link_pull <= drive_req;
    end

    // Open drain: only ever low or released
    assign sda_o  = 1'b0;
    // Gated until first SCL fall, so a stale pull never leaks out
    assign sda_oe = ~(link_pull & link_en);

    // ****************************************
    // Strap capture
    // ****************************************
    // Caught once after reset; later changes are ignored
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            strap_done    <= 1'b0;
            two_wire_en   <= 1'b0;
            four_wire_sel <= 1'b0;
        end else if (!strap_done) begin
            strap_done    <= 1'b1;
            two_wire_en   <= ~pins.strap;
            four_wire_sel <= pins.strap;
        end
    end

    // ****************************************
    // Bus events
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= pins.scl;
            sda_d <= pins.sda;
        end
    end

    assign scl_rise  = pins.scl & ~scl_d;
    assign scl_fall  = ~pins.scl & scl_d;
    assign start_det = two_wire_en & pins.scl & scl_d & sda_d & ~pins.sda;
    assign stop_det  = two_wire_en & pins.scl & scl_d & ~sda_d & pins.sda;
    assign bit_ev    = two_wire_en & scl_rise & (state != i2cs_pkg::ST_IDLE);
    assign byte_end  = bit_ev & (bit_cnt == `I2CS_LAST_BIT);
    assign ack_ev    = bit_ev & (bit_cnt == `I2CS_ACK_SLOT);
    assign next_rx   = {rx[6:0], link_bit};
    assign receiving = (state == i2cs_pkg::ST_ADDR) |
                       (state == i2cs_pkg::ST_REGADDR) |
                       (state == i2cs_pkg::ST_WDATA);

    // General call is write-only, so a read bit with address zero is refused
    assign addr_hit  = (next_rx[7:1] == `I2CS_SLAVE_ADDR) |
                       (gcall_en & (next_rx == {`I2CS_GCALL_ADDR, 1'b0}));

    // ****************************************
    // Transfer sequencing
    // ****************************************
    always_comb begin
        next_state = state;
        case (state)
            i2cs_pkg::ST_ADDR: begin
                if (!drive_req) begin
                    next_state = i2cs_pkg::ST_IGNORE;
                end else if (rx[0]) begin
                    next_state = i2cs_pkg::ST_RDATA;
                end else begin
                    next_state = i2cs_pkg::ST_REGADDR;
                end
            end
            i2cs_pkg::ST_REGADDR: begin
                next_state = i2cs_pkg::ST_WDATA;
            end
            i2cs_pkg::ST_WDATA: begin
                next_state = i2cs_pkg::ST_WDATA;
            end
            i2cs_pkg::ST_RDATA: begin
                // Released line in the slot ends the read
                next_state = link_bit ? i2cs_pkg::ST_IGNORE : i2cs_pkg::ST_RDATA;
            end
            default: begin
                next_state = state;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state   <= i2cs_pkg::ST_IDLE;
            bit_cnt <= 4'h0;
        end else if (stop_det) begin
            state   <= i2cs_pkg::ST_IDLE;
            bit_cnt <= 4'h0;
        end else if (start_det) begin
            state   <= i2cs_pkg::ST_ADDR;
            bit_cnt <= 4'h0;
        end else if (ack_ev) begin
            state   <= next_state;
            bit_cnt <= 4'h0;
        end else if (bit_ev) begin
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    // ****************************************
    // Shift registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx <= 8'h00;
        end else if (bit_ev && receiving && bit_cnt < `I2CS_ACK_SLOT) begin
            rx <= next_rx;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx <= 8'h00;
        end else if (ack_ev && next_state == i2cs_pkg::ST_RDATA) begin
            tx <= rd_data;
        end else if (bit_ev && state == i2cs_pkg::ST_RDATA && bit_cnt < `I2CS_LAST_BIT) begin
            tx <= {tx[6:0], 1'b0};
        end
    end

    // ****************************************
    // Register pointer
    // ****************************************
    // Address bytes keep the pointer, so a later read starts there
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ptr <= 8'h00;
        end else if (byte_end && state == i2cs_pkg::ST_REGADDR) begin
            ptr <= next_rx;
        end else if (byte_end && state == i2cs_pkg::ST_WDATA) begin
            ptr <= ptr + 8'h01;
        end else if (ack_ev && state == i2cs_pkg::ST_RDATA && !link_bit) begin
            ptr <= ptr + 8'h01;
        end
    end

    // Look one ahead while reading, for the byte after an acknowledge
    assign rd_addr = (state == i2cs_pkg::ST_RDATA) ? ptr + 8'h01 : ptr;

    // ****************************************
    // Data line request
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            drive_req <= 1'b0;
        end else if (start_det || stop_det) begin
            drive_req <= 1'b0;
        end else if (byte_end) begin
            if (state == i2cs_pkg::ST_ADDR) begin
                drive_req <= addr_hit;
            end else begin
                // Read bytes release for the master's slot
                drive_req <= receiving;
            end
        end else if (ack_ev) begin
            if (next_state == i2cs_pkg::ST_RDATA) begin
                drive_req <= ~rd_data[7];
            end else begin
                drive_req <= 1'b0;
            end
        end else if (bit_ev && state == i2cs_pkg::ST_RDATA && bit_cnt < `I2CS_LAST_BIT) begin
            drive_req <= ~tx[6];
        end
    end

    // Output armed only after the pull flop has sampled a clean request
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link_en <= 1'b0;
        end else if (start_det || stop_det) begin
            link_en <= 1'b0;
        end else if (scl_fall && state != i2cs_pkg::ST_IDLE) begin
            link_en <= 1'b1;
        end
    end

    // ****************************************
    // Register writes
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_wr_stb <= 1'b0;
            reg_wr     <= '0;
        end else begin
            reg_wr_stb <= byte_end & (state == i2cs_pkg::ST_WDATA);
            if (byte_end && state == i2cs_pkg::ST_WDATA) begin
                reg_wr <= {ptr, next_rx};
            end
        end
    end

    i2cs_regfile u_regs (
        .clk      (clk),
        .rst_n    (rst_n),
        .wr_en    (reg_wr_stb),
        .wr       (reg_wr),
        .rd_addr  (rd_addr),
        .rd_data  (rd_data),
        .gcall_en (gcall_en)
    );

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_addr_ack: assert property (
        byte_end && state == i2cs_pkg::ST_ADDR && next_rx[7:1] == `I2CS_SLAVE_ADDR
        |=> drive_req ##0 bit_cnt == `I2CS_ACK_SLOT
    ) else $error("own address not acknowledged");
    chk_addr_nack: assert property (
        byte_end && state == i2cs_pkg::ST_ADDR && !addr_hit
        |=> !drive_req ##1 (state == i2cs_pkg::ST_ADDR || !drive_req)
    ) else $error("foreign address acknowledged");
    chk_gcall_off: assert property (
        byte_end && state == i2cs_pkg::ST_ADDR && !gcall_en
        && next_rx[7:1] == `I2CS_GCALL_ADDR
        |=> !drive_req
    ) else $error("general call acknowledged while disabled");
    chk_start_addr: assert property (
        start_det && !stop_det
        |=> state == i2cs_pkg::ST_ADDR && bit_cnt == 4'h0 && !drive_req && !link_en
    ) else $error("start did not restart address reception");
    chk_stop_idle: assert property (
        stop_det |=> state == i2cs_pkg::ST_IDLE && !link_en
    ) else $error("stop did not return to idle");
    chk_ack_slot: assert property (
        byte_end && !start_det && !stop_det |=> bit_cnt == `I2CS_ACK_SLOT
    ) else $error("ninth slot not reached after eight bits");
    chk_write_incr: assert property (
        byte_end && state == i2cs_pkg::ST_WDATA
        |=> reg_wr_stb && reg_wr.addr == $past(ptr) && ptr == $past(ptr) + 8'h01
    ) else $error("write byte not stored with increment");
    chk_read_next: assert property (
        ack_ev && state == i2cs_pkg::ST_RDATA && !link_bit
        |=> state == i2cs_pkg::ST_RDATA && ptr == $past(ptr) + 8'h01
            && drive_req == ~tx[7]
    ) else $error("read did not continue with next register");
    chk_read_nack: assert property (
        ack_ev && state == i2cs_pkg::ST_RDATA && link_bit
        |=> state == i2cs_pkg::ST_IGNORE && !drive_req
    ) else $error("read continued after refusal");
    chk_ptr_kept: assert property (
        byte_end && state == i2cs_pkg::ST_REGADDR |=> ptr == $past(next_rx)
    ) else $error("register address not kept as pointer");
    chk_write_quiet: assert property (
        (state == i2cs_pkg::ST_REGADDR || state == i2cs_pkg::ST_WDATA)
        && bit_cnt < `I2CS_ACK_SLOT |-> !drive_req
    ) else $error("data line pulled outside acknowledge");

    chk_strap_block: assert property (
        !two_wire_en |-> state == i2cs_pkg::ST_IDLE && sda_oe && sda_o == 1'b0
    ) else $error("bus activity with two-wire mode off");

    cov_write: cover property (reg_wr_stb);
    cov_read: cover property (ack_ev && state == i2cs_pkg::ST_RDATA && !link_bit);
    cov_restart: cover property (start_det && state == i2cs_pkg::ST_WDATA);
    cov_gcall: cover property (byte_end && state == i2cs_pkg::ST_ADDR && gcall_en && next_rx == 8'h00);

endmodule

`default_nettype wire

// File: i2cs_bfm.sv
`timescale 1ns/100ps
`default_nettype none

// ********
// Two-wire bus master model
// ********
module i2cs_bfm (
    // Bus lines
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    // Released bit read back low: someone else pulled
    int clash = 0;

    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // Also used as repeated start; odd delay keeps SCL off the core clock grid
    task automatic bus_start();
        #1.3;
        if (scl == 1'b0) begin
            #20 sda_pull = 1'b0;
            #20 scl = 1'b1;
        end
        #20 sda_pull = 1'b1;
        #20 scl = 1'b0;
    endtask

    // Clock stands high after this, outside frames
    task automatic bus_stop();
        #20 sda_pull = 1'b1;
        #20 scl = 1'b1;
        #20 sda_pull = 1'b0;
        #40;
    endtask

    task automatic clk_bit(input logic pull, output logic level);
        #20 sda_pull = pull;
        #20 scl = 1'b1;
        #20 level = sda;
        #20 scl = 1'b0;
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic lv;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(~b[i], lv);
            if (b[i] && lv !== 1'b1) clash++;
        end
        clk_bit(1'b0, lv);
        ack = (lv === 1'b0);
    endtask

    // Pull in the ack slot only when more data is wanted
    task automatic recv_byte(input logic more, output logic [7:0] b);
        logic lv;
        for (int i = 7; i >= 0; i--) clk_bit(1'b0, b[i]);
        clk_bit(more, lv);
    endtask
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) check_val(32'(got), 32'(exp))

module tb_top;
    localparam int LIMIT = 40000;
    logic               clk;
    logic               rst_n;
    logic               strap_four_wire;
    logic               scl;
    logic               sda_pull;
    logic               sda_o;
    logic               sda_oe;
    logic               two_wire_en;
    logic               four_wire_sel;
    logic               reg_wr_stb;
    logic               ack;
    logic [7:0]         rd;
    wire logic          sda;
    i2cs_pkg::i2cs_wr_t reg_wr;
    i2cs_pkg::i2cs_wr_t wr_log[$];
    int                 n_errors = 0;
    int                 n_tests = 0;
    int                 cycles = 0;

    // Pull-up resolves a released wire high
    assign sda = (sda_oe === 1'b0 || sda_pull) ? 1'b0 : 1'b1;

    i2cs_top i2cs_top_inst (
        .clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .strap_four_wire(strap_four_wire),
        .two_wire_en(two_wire_en), .four_wire_sel(four_wire_sel),
        .reg_wr_stb(reg_wr_stb), .reg_wr(reg_wr)
    );

    i2cs_bfm i2cs_bfm_inst (.scl(scl), .sda_pull(sda_pull), .sda(sda));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (reg_wr_stb === 1'b1) wr_log.push_back(reg_wr);
        if (cycles == LIMIT) begin
            n_errors++;
            stop_test();
        end
    end

    // ********
    // Shared helpers
    // ********
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic do_reset(input logic strap);
        @(negedge clk);
        rst_n = 1'b0;
        strap_four_wire = strap;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
    endtask

    task automatic send_chk(input logic [7:0] b, input logic exp);
        i2cs_bfm_inst.send_byte(b, ack);
        `CHK(ack, exp);
    endtask

    task automatic start_addr(input logic [7:0] a, input logic exp);
        i2cs_bfm_inst.bus_start();
        send_chk(a, exp);
    endtask

    // ********
    // Scenarios
    // ********
    task automatic test_reset();
        `CHK(two_wire_en, 1'b1);
        `CHK(four_wire_sel, 1'b0);
        `CHK(sda_oe, 1'b1);
        `CHK(sda_o, 1'b0);
        start_addr(8'h00, 1'b0);
        i2cs_bfm_inst.bus_stop();
        $display("test_reset done");
    endtask

    // Burst across the top register checks the pointer wrap
    task automatic test_write();
        wr_log.delete();
        start_addr(8'h30, 1'b1);
        send_chk(8'hFF, 1'b1);
        send_chk(8'hA5, 1'b1);
        send_chk(8'h3C, 1'b1);
        i2cs_bfm_inst.bus_stop();
        `CHK(wr_log.size(), 2);
        `CHK(wr_log[0], {8'hFF, 8'hA5});
        `CHK(wr_log[1], {8'h00, 8'h3C});
        `CHK(i2cs_bfm_inst.clash, 0);
        $display("test_write done");
    endtask

    task automatic test_read();
        start_addr(8'h30, 1'b1);
        send_chk(8'hFF, 1'b1);
        start_addr(8'h31, 1'b1);
        i2cs_bfm_inst.recv_byte(1'b1, rd);
        `CHK(rd, 8'hA5);
        i2cs_bfm_inst.recv_byte(1'b0, rd);
        `CHK(rd, 8'h3C);
        #20;
        `CHK(sda_oe, 1'b1);
        i2cs_bfm_inst.bus_stop();
        `CHK(wr_log.size(), 2);
        $display("test_read done");
    endtask

    // Silence must last until the next start
    task automatic test_wrong_addr();
        logic [7:0] bad[4] = '{8'h32, 8'h10, 8'hB0, 8'h01};
        foreach (bad[i]) begin
            start_addr(bad[i], 1'b0);
            send_chk(8'h00, 1'b0);
        end
        i2cs_bfm_inst.bus_stop();
        `CHK(i2cs_bfm_inst.clash, 0);
        $display("test_wrong_addr done");
    endtask

    task automatic test_gcall();
        start_addr(8'h30, 1'b1);
        send_chk(8'h22, 1'b1);
        send_chk(8'h20, 1'b1);
        start_addr(8'h00, 1'b1);
        send_chk(8'h40, 1'b1);
        send_chk(8'h77, 1'b1);
        start_addr(8'h01, 1'b0);
        i2cs_bfm_inst.bus_stop();
        `CHK(wr_log[$], {8'h40, 8'h77});
        $display("test_gcall done");
    endtask

    // Reset also clears the general-call enable
    task automatic test_strap();
        do_reset(1'b1);
        `CHK(two_wire_en, 1'b0);
        `CHK(four_wire_sel, 1'b1);
        start_addr(8'h30, 1'b0);
        i2cs_bfm_inst.bus_stop();
        do_reset(1'b0);
        `CHK(two_wire_en, 1'b1);
        start_addr(8'h00, 1'b0);
        i2cs_bfm_inst.bus_stop();
        $display("test_strap done");
    endtask

    initial begin
        rst_n = 1'b0;
        strap_four_wire = 1'b0;
        do_reset(1'b0);
        test_reset();
        test_write();
        test_read();
        test_wrong_addr();
        test_gcall();
        test_strap();
        stop_test();
    end
endmodule
`default_nettype wire
